// >>> fpt_pkg.sv
package fpt_pkg;

  // ==========================================================================
  // Flash array geometry
  // ==========================================================================
  localparam int FLASH_BYTES = 131072;
  localparam int ADDR_W      = 17;
  localparam int WORD_AW     = 15;
  localparam int WORD_LSB    = 2;
  localparam int BLOCK_LSB   = 10;
  localparam int UNIT_LSB    = 11;
  localparam int UNIT_BITS   = 6;
  localparam int UNITS       = 64;
  localparam int BLK_WORD_W  = 8;
  localparam logic [31:0] ERASED_WORD  = 32'hffffffff;
  localparam logic [31:0] BLOCKED_WORD = 32'h00000000;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [11:0] OFS_ADDR = 12'h000;
  localparam logic [11:0] OFS_DATA = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_RIS  = 12'h00c;
  localparam logic [11:0] OFS_IM   = 12'h010;
  localparam logic [11:0] OFS_MISC = 12'h014;
  localparam logic [11:0] OFS_USEC = 12'h140;
  localparam logic [11:0] OFS_RE0  = 12'h200;
  localparam logic [11:0] OFS_RE1  = 12'h204;
  localparam logic [11:0] OFS_PE0  = 12'h400;
  localparam logic [11:0] OFS_PE1  = 12'h404;

  // ==========================================================================
  // Control register fields and commit addresses
  // ==========================================================================
  localparam logic [15:0] CTRL_KEY        = 16'ha442;
  localparam int          CTRL_KEY_LSB    = 16;
  localparam int          CTRL_WRITE_BIT  = 0;
  localparam int          CTRL_ERASE_BIT  = 1;
  localparam int          CTRL_MERASE_BIT = 2;
  localparam int          CTRL_COMMIT_BIT = 3;
  localparam logic [31:0] COMMIT_RE0      = 32'h00000000;
  localparam logic [31:0] COMMIT_PE0      = 32'h00000001;
  localparam logic [31:0] COMMIT_RE1      = 32'h00000002;
  localparam logic [31:0] COMMIT_PE1      = 32'h00000003;

  // ==========================================================================
  // Reset values and timing
  // ==========================================================================
  localparam logic [7:0]  USEC_RESET      = 8'h31;
  localparam logic [63:0] PROT_FACTORY    = 64'hffffffffffffffff;
  localparam int          PROG_TIME_US    = 20;
  localparam int          ERASE_TIME_US   = 1000;
  localparam int          WAIT_W          = 16;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } fpt_apb_req_type;

  typedef struct packed {
    logic              req;
    logic              fetch;
    logic [ADDR_W-1:0] addr;
  } fpt_rd_req_type;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_PREAD  = 5'b00010,
    ST_PWRITE = 5'b00100,
    ST_FILL   = 5'b01000,
    ST_WAIT   = 5'b10000
  } fpt_state_type;

endpackage : fpt_pkg

// >>> fpt_flash_mem.sv
`timescale 1ns/100ps
`default_nettype none

module fpt_flash_mem #(
  parameter int AW = 15,
  parameter int DW = 32
) (
  input  wire logic          clk_sys_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] wdata_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [DW-1:0] rdata_q;

  // ==========================================================================
  // Single port, registered read
  // ==========================================================================
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem_q[addr_in] <= wdata_in;
    end
    rdata_q <= mem_q[addr_in];
  end

  assign rdata_out = rdata_q;

endmodule : fpt_flash_mem

`default_nettype wire

// >>> fpt_flash_ctrl.sv
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Flash splits into 1-KB blocks; erasing a block writes all ones.
// - Programming a word can only clear bits; ones turn zero, zeros stay.
// - Two adjacent erase blocks form one 2-KB unit with its own policy.
// - Array is 128 KB; protection covers all sixty-four 2-KB units.
// - Program and erase timing scales by software cycles-per-microsecond value.
// - One bit per policy per unit, in two pairs of 32-bit registers.
// - Program-enable one allows program and erase; zero refuses them.
// - Read-enable one allows all reads; zero allows instruction fetch only.
// - Read-enable zero denies processor data reads and debugger reads.
// - Program-enable one, read-enable zero: writes, erases, fetches work; reads fail.
// - Program or erase of write-protected unit blocked; mask bit raises interrupt.
// - Blocked data read returns an all-zero word.
// - Blocked read also flags a maskable violation interrupt.
// - Factory defaults set all program and read enable bits to one.
// - Protection writes act at once; commit makes them nonvolatile.
// - Uncommitted cleared bits return to committed value after power-on reset.
module fpt_flash_ctrl #(
  parameter int PROG_US  = fpt_pkg::PROG_TIME_US,
  parameter int ERASE_US = fpt_pkg::ERASE_TIME_US
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_in,
  input  wire logic                    nv_factory_in,
  input  wire fpt_pkg::fpt_apb_req_type apb_in,
  output logic                         pready_out,
  output logic                         pslverr_out,
  output logic [31:0]                  prdata_out,
  input  wire fpt_pkg::fpt_rd_req_type rd_in,
  output logic                         rd_ready_out,
  output logic                         rd_valid_out,
  output logic                         rd_blocked_out,
  output logic [31:0]                  rd_data_out,
  output logic                         busy_out,
  output logic                         flash_int_out
);

  if (PROG_US < 1 || PROG_US >= (1 << fpt_pkg::WAIT_W)) begin : g_bad_prog
    $error("PROG_US out of range");
  end
  if (ERASE_US < 1 || ERASE_US >= (1 << fpt_pkg::WAIT_W)) begin : g_bad_erase
    $error("ERASE_US out of range");
  end
  if (fpt_pkg::UNITS << fpt_pkg::UNIT_LSB != fpt_pkg::FLASH_BYTES) begin : g_bad_units
    $error("protection units do not cover the flash array");
  end
  if (fpt_pkg::WORD_AW + fpt_pkg::WORD_LSB != fpt_pkg::ADDR_W) begin : g_bad_words
    $error("word address width does not match the flash size");
  end

  localparam logic [fpt_pkg::WAIT_W-1:0] PROG_CNT  = PROG_US[fpt_pkg::WAIT_W-1:0];
  localparam logic [fpt_pkg::WAIT_W-1:0] ERASE_CNT = ERASE_US[fpt_pkg::WAIT_W-1:0];

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    fpt_pkg::fpt_state_type        st;
    logic [31:0]                   target_addr;
    logic [31:0]                   wdata;
    logic [7:0]                    cycles_per_us_reload;
    logic [63:0]                   read_enable_mask;
    logic [63:0]                   program_enable_mask;
    logic [63:0]                   nv_read_enable;
    logic [63:0]                   nv_program_enable;
    logic                          viol_raw;
    logic                          access_violation_int_mask;
    logic [2:0]                    cmd_busy;
    logic [fpt_pkg::WORD_AW-1:0]   word;
    logic [fpt_pkg::WORD_AW-1:0]   last_word;
    logic [7:0]                    us_cnt;
    logic [fpt_pkg::WAIT_W-1:0]    wait_cnt;
    logic                          ack;
    logic                          slverr;
    logic [31:0]                   prdata;
    logic                          rd_v1;
    logic                          rd_blk1;
    logic                          rd_valid;
    logic                          rd_blocked;
    logic [31:0]                   rd_data;
  } fpt_ctrl_state_type;

  fpt_ctrl_state_type q, d;

  logic                        mem_we;
  logic [fpt_pkg::WORD_AW-1:0] mem_addr;
  logic [31:0]                 mem_wdata;
  logic [31:0]                 mem_rdata;
  logic                        apb_acc;
  logic                        apb_wr;
  logic                        tick;
  logic                        viol;
  logic                        key_ok;
  logic [31:0]                 wr;

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  function automatic logic [fpt_pkg::UNIT_BITS-1:0] unit_of(input logic [31:0] a);
    unit_of = a[fpt_pkg::UNIT_LSB +: fpt_pkg::UNIT_BITS];
  endfunction : unit_of

  function automatic logic is_mapped(input logic [11:0] ofs);
    unique case (ofs)
      fpt_pkg::OFS_ADDR,
      fpt_pkg::OFS_DATA,
      fpt_pkg::OFS_CTRL,
      fpt_pkg::OFS_RIS,
      fpt_pkg::OFS_IM,
      fpt_pkg::OFS_MISC,
      fpt_pkg::OFS_USEC,
      fpt_pkg::OFS_RE0,
      fpt_pkg::OFS_RE1,
      fpt_pkg::OFS_PE0,
      fpt_pkg::OFS_PE1: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // ==========================================================================
  // Flash array
  // ==========================================================================
  fpt_flash_mem #(
    .AW (fpt_pkg::WORD_AW),
    .DW (32)
  ) u_mem (
    .clk_sys_in (clk_sys_in),
    .we_in      (mem_we),
    .addr_in    (mem_addr),
    .wdata_in   (mem_wdata),
    .rdata_out  (mem_rdata)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    d         = q;
    mem_we    = 1'b0;
    mem_addr  = rd_in.addr[fpt_pkg::WORD_LSB +: fpt_pkg::WORD_AW];
    mem_wdata = fpt_pkg::ERASED_WORD;
    viol      = 1'b0;
    apb_acc   = apb_in.psel & apb_in.penable;
    apb_wr    = apb_acc & q.ack & apb_in.pwrite & is_mapped(apb_in.paddr);
    wr        = apb_in.pwdata;
    key_ok    = (wr[fpt_pkg::CTRL_KEY_LSB +: 16] == fpt_pkg::CTRL_KEY);

    // Microsecond prescaler, reloaded from software value
    tick     = (q.us_cnt == 8'h00);
    d.us_cnt = tick ? q.cycles_per_us_reload : q.us_cnt - 8'h01;

    // Read port: fetches always pass, data reads need read enable
    d.rd_v1    = rd_in.req & (q.st == fpt_pkg::ST_IDLE);
    d.rd_blk1  = rd_in.req & ~rd_in.fetch
               & ~q.read_enable_mask[unit_of(32'(rd_in.addr))];
    d.rd_valid = q.rd_v1;
    if (q.rd_v1) begin
      d.rd_blocked = q.rd_blk1;
      d.rd_data    = q.rd_blk1 ? fpt_pkg::BLOCKED_WORD : mem_rdata;
      if (q.rd_blk1) begin
        viol = 1'b1;
      end
    end

    // APB: one wait state, read data sampled into a register
    d.ack = apb_acc & ~q.ack;
    if (d.ack) begin
      d.slverr = ~is_mapped(apb_in.paddr);
      unique case (apb_in.paddr)
        fpt_pkg::OFS_ADDR: d.prdata = q.target_addr;
        fpt_pkg::OFS_DATA: d.prdata = q.wdata;
        fpt_pkg::OFS_CTRL: d.prdata = {29'h0, q.cmd_busy};
        fpt_pkg::OFS_RIS:  d.prdata = {31'h0, q.viol_raw};
        fpt_pkg::OFS_IM:   d.prdata = {31'h0, q.access_violation_int_mask};
        fpt_pkg::OFS_MISC: d.prdata = {31'h0, q.viol_raw & q.access_violation_int_mask};
        fpt_pkg::OFS_USEC: d.prdata = {24'h0, q.cycles_per_us_reload};
        fpt_pkg::OFS_RE0:  d.prdata = q.read_enable_mask[31:0];
        fpt_pkg::OFS_RE1:  d.prdata = q.read_enable_mask[63:32];
        fpt_pkg::OFS_PE0:  d.prdata = q.program_enable_mask[31:0];
        fpt_pkg::OFS_PE1:  d.prdata = q.program_enable_mask[63:32];
        default:           d.prdata = 32'h00000000;
      endcase
    end

    if (apb_wr) begin
      unique case (apb_in.paddr)
        fpt_pkg::OFS_ADDR: d.target_addr = wr;
        fpt_pkg::OFS_DATA: d.wdata = wr;
        fpt_pkg::OFS_IM:   d.access_violation_int_mask = wr[0];
        fpt_pkg::OFS_MISC: d.viol_raw = q.viol_raw & ~wr[0];
        fpt_pkg::OFS_USEC: d.cycles_per_us_reload = wr[7:0];
        // Working copies change at once; nonvolatile copies only on commit
        fpt_pkg::OFS_RE0:  d.read_enable_mask[31:0] = wr;
        fpt_pkg::OFS_RE1:  d.read_enable_mask[63:32] = wr;
        fpt_pkg::OFS_PE0:  d.program_enable_mask[31:0] = wr;
        fpt_pkg::OFS_PE1:  d.program_enable_mask[63:32] = wr;

        fpt_pkg::OFS_CTRL: begin
          // Commands are ignored without the key or while one is running
          if (key_ok && q.st == fpt_pkg::ST_IDLE) begin
            if (wr[fpt_pkg::CTRL_WRITE_BIT]) begin
              if (q.program_enable_mask[unit_of(q.target_addr)]) begin
                d.st       = fpt_pkg::ST_PREAD;
                d.word     = q.target_addr[fpt_pkg::WORD_LSB +: fpt_pkg::WORD_AW];
                d.cmd_busy = 3'b001;
              end else begin
                viol = 1'b1;
              end
            end else if (wr[fpt_pkg::CTRL_ERASE_BIT]) begin
              if (q.program_enable_mask[unit_of(q.target_addr)]) begin
                d.st        = fpt_pkg::ST_FILL;
                d.word      = {q.target_addr[fpt_pkg::BLOCK_LSB +: 7], {fpt_pkg::BLK_WORD_W{1'b0}}};
                d.last_word = {q.target_addr[fpt_pkg::BLOCK_LSB +: 7], {fpt_pkg::BLK_WORD_W{1'b1}}};
                d.cmd_busy  = 3'b010;
              end else begin
                viol = 1'b1;
              end
            end else if (wr[fpt_pkg::CTRL_MERASE_BIT]) begin
              // Mass erase would wipe protected units, so any protected unit refuses it
              if (&q.program_enable_mask) begin
                d.st        = fpt_pkg::ST_FILL;
                d.word      = '0;
                d.last_word = '1;
                d.cmd_busy  = 3'b100;
              end else begin
                viol = 1'b1;
              end
            end else if (wr[fpt_pkg::CTRL_COMMIT_BIT]) begin
              // Nonvolatile bits can only go from one to zero
              unique case (q.target_addr)
                fpt_pkg::COMMIT_RE0: d.nv_read_enable[31:0] =
                  q.nv_read_enable[31:0] & q.read_enable_mask[31:0];
                fpt_pkg::COMMIT_RE1: d.nv_read_enable[63:32] =
                  q.nv_read_enable[63:32] & q.read_enable_mask[63:32];
                fpt_pkg::COMMIT_PE0: d.nv_program_enable[31:0] =
                  q.nv_program_enable[31:0] & q.program_enable_mask[31:0];
                fpt_pkg::COMMIT_PE1: d.nv_program_enable[63:32] =
                  q.nv_program_enable[63:32] & q.program_enable_mask[63:32];
                default: ;
              endcase
            end
          end
        end
        default: ;
      endcase
    end

    // ========================================================================
    // Program and erase sequencer
    // ========================================================================
    unique case (q.st)
      fpt_pkg::ST_IDLE: ;

      // Read the old word first so that programming can only clear bits
      fpt_pkg::ST_PREAD: begin
        mem_addr = q.word;
        d.st     = fpt_pkg::ST_PWRITE;
      end

      fpt_pkg::ST_PWRITE: begin
        mem_we     = 1'b1;
        mem_addr   = q.word;
        mem_wdata  = mem_rdata & q.wdata;
        d.wait_cnt = PROG_CNT;
        d.st       = fpt_pkg::ST_WAIT;
      end

      // One word per cycle; the wait after the last word covers the erase pulse
      fpt_pkg::ST_FILL: begin
        mem_we    = 1'b1;
        mem_addr  = q.word;
        mem_wdata = fpt_pkg::ERASED_WORD;
        if (q.word == q.last_word) begin
          d.wait_cnt = ERASE_CNT;
          d.st       = fpt_pkg::ST_WAIT;
        end else begin
          d.word = q.word + 1'b1;
        end
      end

      // The first tick may come at once, so a wait can be short by up to one tick
      fpt_pkg::ST_WAIT: begin
        if (tick) begin
          if (q.wait_cnt == 1) begin
            d.st       = fpt_pkg::ST_IDLE;
            d.cmd_busy = 3'b000;
          end else begin
            d.wait_cnt = q.wait_cnt - 1'b1;
          end
        end
      end
    endcase

    // Raw flag is set regardless of the mask; a new event beats a clear
    if (viol) begin
      d.viol_raw = 1'b1;
    end

    if (rst_in) begin
      d = '0;
      d.st                   = fpt_pkg::ST_IDLE;
      d.cycles_per_us_reload = fpt_pkg::USEC_RESET;
      d.us_cnt               = fpt_pkg::USEC_RESET;
      // Committed copies survive reset unless the factory strap is high
      d.nv_read_enable       = nv_factory_in ? fpt_pkg::PROT_FACTORY : q.nv_read_enable;
      d.nv_program_enable    = nv_factory_in ? fpt_pkg::PROT_FACTORY : q.nv_program_enable;
      // Working copies reload from the committed values at reset
      d.read_enable_mask     = d.nv_read_enable;
      d.program_enable_mask  = d.nv_program_enable;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    q <= d;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign pready_out     = q.ack;
  assign pslverr_out    = q.ack & q.slverr;
  assign prdata_out     = q.prdata;
  // Reads stall while the array changes, so no read sees a half-written word
  assign rd_ready_out   = (q.st == fpt_pkg::ST_IDLE);
  assign rd_valid_out   = q.rd_valid;
  assign rd_blocked_out = q.rd_blocked;
  assign rd_data_out    = q.rd_data;
  assign busy_out       = (q.st != fpt_pkg::ST_IDLE);
  // Level output, held until software clears the raw flag
  assign flash_int_out  = q.viol_raw & q.access_violation_int_mask;

endmodule : fpt_flash_ctrl

`default_nettype wire

// >>> fpt_flash_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module fpt_flash_ctrl_chk #(
  parameter int PROG_US  = 2,
  parameter int ERASE_US = 3
) (
  input wire logic                     clk_sys_in,
  input wire logic                     rst_in,
  input wire fpt_pkg::fpt_apb_req_type apb_in,
  input wire logic                     pready_out,
  input wire logic                     pslverr_out,
  input wire logic [31:0]              prdata_out,
  input wire fpt_pkg::fpt_rd_req_type  rd_in,
  input wire logic                     rd_ready_out,
  input wire logic                     rd_valid_out,
  input wire logic                     rd_blocked_out,
  input wire logic [31:0]              rd_data_out,
  input wire logic                     busy_out,
  input wire logic                     flash_int_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // ==========================================================================
  // Register bus and read port timing
  // ==========================================================================
  AST_APB_ANSWER: assert property ($rose(apb_in.psel && apb_in.penable) |=> pready_out)
    else $error("register access not answered after one wait state");
  AST_PREADY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held longer than one cycle");
  AST_ERR_QUALIFIED: assert property (pslverr_out |-> pready_out && prdata_out == 32'h00000000)
    else $error("error response without ready or with data");
  AST_RD_ANSWER: assert property (rd_in.req && rd_ready_out |-> ##2 rd_valid_out)
    else $error("flash read not answered two cycles after acceptance");
  AST_RD_CAUSE: assert property (rd_valid_out |-> $past(rd_in.req && rd_ready_out, 2))
    else $error("read answer without a request");
  AST_FETCH_OPEN: assert property (rd_in.req && rd_ready_out && rd_in.fetch |-> ##2 !rd_blocked_out)
    else $error("instruction fetch was refused");
  AST_BLOCKED_ZERO: assert property (rd_valid_out && rd_blocked_out |-> rd_data_out == 32'h00000000)
    else $error("refused read returned stored data");
  // Even the shortest program waits PROG_US ticks of at least one cycle each
  AST_BUSY_SPAN: assert property ($rose(busy_out) |-> busy_out[*4])
    else $error("program or erase ended too early");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    rst_in |=> !pready_out && !rd_valid_out && !busy_out && !flash_int_out)
    else $error("outputs active after reset");
endmodule : fpt_flash_ctrl_chk
bind fpt_flash_ctrl fpt_flash_ctrl_chk #(.PROG_US(PROG_US), .ERASE_US(ERASE_US)) u_fpt_flash_ctrl_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .apb_in(apb_in), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .prdata_out(prdata_out), .rd_in(rd_in), .rd_ready_out(rd_ready_out),
  .rd_valid_out(rd_valid_out), .rd_blocked_out(rd_blocked_out), .rd_data_out(rd_data_out),
  .busy_out(busy_out), .flash_int_out(flash_int_out));
`default_nettype wire

// >>> fpt_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpt_core_model (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rd_ready_in,
  output var fpt_pkg::fpt_rd_req_type  rd_out
);
  initial rd_out = '0;
  // ==========================================================================
  // Instruction or data side read, held until the controller takes it
  // ==========================================================================
  task automatic read_word(input logic [16:0] addr, input logic fetch, input int gap);
    repeat (gap) @(posedge clk_sys_in);
    @(posedge clk_sys_in);
    rd_out <= '{req: 1'b1, fetch: fetch, addr: addr};
    do @(negedge clk_sys_in); while (rd_ready_in !== 1'b1);
    @(posedge clk_sys_in);
    // Released lines show junk so a stale address can never pass for a new one
    rd_out <= '{req: 1'b0, fetch: ~fetch, addr: ~addr};
  endtask : read_word
endmodule : fpt_core_model
`default_nettype wire

// >>> flash_protect_timing_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module flash_protect_timing_ctrl_bench;
  localparam int PU = 2;
  localparam int EU = 3;
  logic                     clk_sys_in = 1'b0;
  logic                     rst_in = 1'b1;
  logic                     nv_factory_in = 1'b1;
  fpt_pkg::fpt_apb_req_type apb = '0;
  wire fpt_pkg::fpt_rd_req_type rd_req;
  logic        pready, pslverr, busy, fint, rd_ready, rd_valid, rd_blocked;
  logic [31:0] prdata, rd_data, wd, wd2;
  logic [31:0] seed = 32'h77149b28;
  logic [33:0] apb_q[$];
  logic [32:0] rd_q[$];
  logic [33:0] note;
  logic [11:0] prot_ofs[4] = '{fpt_pkg::OFS_RE0, fpt_pkg::OFS_RE1, fpt_pkg::OFS_PE0, fpt_pkg::OFS_PE1};
  int          err_count = 0;
  int          compares = 0;
  fpt_flash_ctrl #(.PROG_US(PU), .ERASE_US(EU)) u_fpt_flash_ctrl (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .nv_factory_in(nv_factory_in), .apb_in(apb),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .rd_in(rd_req),
    .rd_ready_out(rd_ready), .rd_valid_out(rd_valid), .rd_blocked_out(rd_blocked),
    .rd_data_out(rd_data), .busy_out(busy), .flash_int_out(fint));
  fpt_core_model u_fpt_core_model (.clk_sys_in(clk_sys_in), .rd_ready_in(rd_ready), .rd_out(rd_req));
  always #50 clk_sys_in = ~clk_sys_in;
  // ==========================================================================
  // Checking
  // ==========================================================================
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(negedge clk_sys_in) begin
    if (pready === 1'b1 && apb_q.size() > 0) begin
      note = apb_q.pop_front();
      if (note[33]) check({pslverr, prdata}, note[32:0]);
    end
    if (rd_valid === 1'b1 && rd_q.size() > 0) check({rd_blocked, rd_data}, rd_q.pop_front());
  end
  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] exp);
    apb_q.push_back(exp);
    @(posedge clk_sys_in);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys_in);
    apb.penable <= 1'b1;
    do @(negedge clk_sys_in); while (pready !== 1'b1);
    @(posedge clk_sys_in);
    apb <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~a, pwdata: ~d};
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 34'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {2'b10, e});
  endtask : rd
  task automatic fr(input logic [16:0] a, input logic f, input logic b, input logic [31:0] e, input int gap);
    rd_q.push_back({b, e});
    u_fpt_core_model.read_word(a, f, gap);
  endtask : fr
  // Starts a flash operation and checks its busy span is at least lo cycles
  task automatic op(input logic [31:0] a, input logic [15:0] cmd, input int lo);
    int n;
    n = 0;
    wr(fpt_pkg::OFS_ADDR, a);
    wr(fpt_pkg::OFS_CTRL, {fpt_pkg::CTRL_KEY, cmd});
    @(posedge clk_sys_in);
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge clk_sys_in);
      n++;
    end
    check(n >= lo && n < 3000, 1'b1);
  endtask : op
  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
  endtask : do_reset
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #(20000 * 100);
    err_count++;
    end_of_test();
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    do_reset();
    rd(fpt_pkg::OFS_USEC, 32'h31);
    for (int i = 0; i < 4; i++) rd(prot_ofs[i], 32'hffffffff);
    xfer(1'b0, 12'h0f0, 32'h0, {2'b11, 32'h0});
    $display("reset values done");
    op(32'h0, 16'h0002, 256 + (EU - 1) * (fpt_pkg::USEC_RESET + 1));
    wr(fpt_pkg::OFS_USEC, 32'h1);
    op(32'h0, 16'h0002, 256 + (EU - 1) * 2);
    fr(17'h0, 1'b0, 1'b0, fpt_pkg::ERASED_WORD, 0);
    fr(17'h3fc, 1'b0, 1'b0, fpt_pkg::ERASED_WORD, 3);
    wd = $random(seed);
    wd2 = $random(seed);
    wr(fpt_pkg::OFS_DATA, wd);
    op(32'h4, 16'h0001, PU * 2);
    wr(fpt_pkg::OFS_DATA, wd2);
    op(32'h4, 16'h0001, PU * 2);
    fr(17'h4, 1'b0, 1'b0, wd & wd2, 0);
    $display("erase and program done");
    op(32'h800, 16'h0002, 256);
    op(32'hc00, 16'h0002, 256);
    wr(fpt_pkg::OFS_DATA, wd2);
    op(32'hc04, 16'h0001, PU * 2);
    wr(fpt_pkg::OFS_PE0, ~32'h2);
    wr(fpt_pkg::OFS_DATA, 32'h0);
    op(32'h800, 16'h0001, 0);
    op(32'hc00, 16'h0002, 0);
    fr(17'h800, 1'b0, 1'b0, fpt_pkg::ERASED_WORD, 0);
    fr(17'hc04, 1'b0, 1'b0, wd2, 0);
    rd(fpt_pkg::OFS_RIS, 32'h1);
    rd(fpt_pkg::OFS_MISC, 32'h0);
    check(fint, 1'b0);
    wr(fpt_pkg::OFS_IM, 32'h1);
    rd(fpt_pkg::OFS_MISC, 32'h1);
    check(fint, 1'b1);
    wr(fpt_pkg::OFS_MISC, 32'h1);
    rd(fpt_pkg::OFS_RIS, 32'h0);
    op(32'h0, 16'h0004, 0);
    rd(fpt_pkg::OFS_RIS, 32'h1);
    wr(fpt_pkg::OFS_MISC, 32'h1);
    $display("program protection done");
    wr(fpt_pkg::OFS_PE0, 32'hffffffff);
    wr(fpt_pkg::OFS_RE0, ~32'h2);
    wd = $random(seed);
    wr(fpt_pkg::OFS_DATA, wd);
    op(32'h800, 16'h0001, PU * 2);
    fr(17'h800, 1'b0, 1'b1, 32'h0, 0);
    fr(17'h800, 1'b1, 1'b0, wd, 0);
    fr(17'h0, 1'b0, 1'b0, fpt_pkg::ERASED_WORD, 0);
    rd(fpt_pkg::OFS_RIS, 32'h1);
    wr(fpt_pkg::OFS_MISC, 32'h1);
    $display("read protection done");
    wr(fpt_pkg::OFS_RE1, ~32'h1);
    wr(fpt_pkg::OFS_ADDR, fpt_pkg::COMMIT_RE1);
    wr(fpt_pkg::OFS_CTRL, {fpt_pkg::CTRL_KEY, 16'h0008});
    wr(fpt_pkg::OFS_ADDR, fpt_pkg::COMMIT_RE0);
    wr(fpt_pkg::OFS_CTRL, 32'h00000008);
    nv_factory_in <= 1'b0;
    do_reset();
    rd(fpt_pkg::OFS_RE0, 32'hffffffff);
    rd(fpt_pkg::OFS_RE1, 32'hfffffffe);
    rd(fpt_pkg::OFS_USEC, 32'h31);
    check(apb_q.size() + rd_q.size(), 33'h0);
    $display("commit done");
    end_of_test();
  end
endmodule : flash_protect_timing_ctrl_bench
`default_nettype wire
